//--- dv/test_core_status_bank_select.sv
`timescale 1ns/10ps
module test_core_status_bank_select;
    typedef struct packed {
        csbs_pkg::csbs_op_type op;
        logic [6:0]            fa;
        logic [7:0]            w;
        logic [7:0]            a;
        logic [1:0]            ld;
        logic [7:0]            res;
        logic [8:0]            addr;
        logic [7:0]            st;
    } csbs_row_type;

    logic                  sys_clk;
    logic                  rst;
    logic                  instrValid;
    csbs_pkg::csbs_op_type instrOp;
    logic [6:0]            fileAddr;
    logic [7:0]            workingReg;
    logic [7:0]            literalVal;
    logic                  useLiteral;
    logic                  destFile;
    logic [2:0]            bitSel;
    logic [7:0]            memRdData;
    logic                  watchdogClearInstr;
    logic                  sleepInstr;
    logic                  watchdogTimeout;
    logic [8:0]            dataAddr;
    logic [7:0]            aluResult;
    logic                  memWrEn;
    logic [7:0]            statusOut;
    logic [7:0]            indirectPointer;
    logic [7:0]            prevSt;
    int                    mismatches;
    int                    num_checks;

    // Ops, file address, W, operand, {literal,dest}, result, address, status
    // Bit index rides in W[2:0]; each row sees the status left by the last
    csbs_row_type rows [20] = '{
    '{csbs_pkg::CSBS_OP_ADD,7'h20,8'h01,8'hFF,2'h0,8'h00,9'h020,8'h1F},
    '{csbs_pkg::CSBS_OP_ADD,7'h20,8'h08,8'h08,2'h0,8'h10,9'h020,8'h1A},
    '{csbs_pkg::CSBS_OP_SUB,7'h20,8'h06,8'h05,2'h0,8'hFF,9'h020,8'h18},
    '{csbs_pkg::CSBS_OP_SUB,7'h20,8'h01,8'h10,2'h0,8'h0F,9'h020,8'h19},
    '{csbs_pkg::CSBS_OP_RLF,7'h20,8'h00,8'h01,2'h0,8'h03,9'h020,8'h18},
    '{csbs_pkg::CSBS_OP_RRF,7'h20,8'h00,8'h01,2'h0,8'h00,9'h020,8'h19},
    '{csbs_pkg::CSBS_OP_AND,7'h20,8'h0F,8'hF0,2'h0,8'h00,9'h020,8'h1D},
    '{csbs_pkg::CSBS_OP_MOVE,7'h03,8'hE2,8'h00,2'h1,8'hE2,9'h003,8'hFA},
    '{csbs_pkg::CSBS_OP_ADD,7'h20,8'h00,8'h01,2'h0,8'h01,9'h1A0,8'hF8},
    '{csbs_pkg::CSBS_OP_MOVE,7'h04,8'h5A,8'h00,2'h1,8'h5A,9'h184,8'hF8},
    '{csbs_pkg::CSBS_OP_OR,7'h00,8'h00,8'h00,2'h0,8'h00,9'h15A,8'hFC},
    '{csbs_pkg::CSBS_OP_CLR,7'h03,8'h00,8'h00,2'h1,8'h00,9'h183,8'h1C},
    '{csbs_pkg::CSBS_OP_BSF,7'h03,8'h05,8'h1C,2'h1,8'h3C,9'h003,8'h3C},
    '{csbs_pkg::CSBS_OP_OR,7'h00,8'h00,8'h80,2'h0,8'h80,9'h05A,8'h38},
    '{csbs_pkg::CSBS_OP_XOR,7'h10,8'h55,8'h55,2'h0,8'h00,9'h090,8'h3C},
    '{csbs_pkg::CSBS_OP_SWAP,7'h10,8'h00,8'h12,2'h1,8'h21,9'h090,8'h3C},
    '{csbs_pkg::CSBS_OP_BCF,7'h03,8'h05,8'h3C,2'h1,8'h1C,9'h083,8'h1C},
    '{csbs_pkg::CSBS_OP_ADD,7'h03,8'h01,8'hFF,2'h3,8'h00,9'h003,8'h1F},
    '{csbs_pkg::CSBS_OP_SUB,7'h03,8'h03,8'h02,2'h3,8'hFF,9'h003,8'h18},
    '{csbs_pkg::CSBS_OP_ADD,7'h03,8'hC7,8'h18,2'h1,8'hDF,9'h003,8'hD8}};

    csbs_status_bank dut (
        .sys_clk            (sys_clk),
        .rst                (rst),
        .instrValid         (instrValid),
        .instrOp            (instrOp),
        .fileAddr           (fileAddr),
        .workingReg         (workingReg),
        .literalVal         (literalVal),
        .useLiteral         (useLiteral),
        .destFile           (destFile),
        .bitSel             (bitSel),
        .memRdData          (memRdData),
        .watchdogClearInstr (watchdogClearInstr),
        .sleepInstr         (sleepInstr),
        .watchdogTimeout    (watchdogTimeout),
        .dataAddr           (dataAddr),
        .aluResult          (aluResult),
        .memWrEn            (memWrEn),
        .statusOut          (statusOut),
        .indirectPointer    (indirectPointer)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk9

    task end_of_test;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    // Back to back: the status check sees the previous row's update
    task automatic run_row(input csbs_row_type r);
        logic wrExp;
        wrExp = (r.ld == 2'h1) && (r.fa != 7'h03) && (r.fa != 7'h04);
        @(posedge sys_clk);
        instrValid <= 1'b1;
        instrOp    <= r.op;
        fileAddr   <= r.fa;
        workingReg <= r.w;
        bitSel     <= r.w[2:0];
        literalVal <= r.a;
        // Memory bus shows the inverse so a wrong operand pick is seen
        memRdData  <= r.ld[1] ? ~r.a : r.a;
        useLiteral <= r.ld[1];
        destFile   <= r.ld[0];
        @(negedge sys_clk);
        chk8(statusOut, prevSt);
        chk8(aluResult, r.res);
        chk9(dataAddr, r.addr);
        chk8({7'h00, memWrEn}, {7'h00, wrExp});
        prevSt = r.st;
    endtask : run_row

    task automatic ev(input logic [2:0] e, input logic [7:0] exp);
        @(posedge sys_clk);
        {watchdogTimeout, sleepInstr, watchdogClearInstr} <= e;
        @(posedge sys_clk);
        {watchdogTimeout, sleepInstr, watchdogClearInstr} <= 3'h0;
        @(negedge sys_clk);
        chk8(statusOut, exp);
        prevSt = exp;
    endtask : ev

    initial begin
        rst = 1'b1;
        instrValid = 1'b0;
        instrOp = csbs_pkg::CSBS_OP_NONE;
        {fileAddr, workingReg, literalVal, memRdData} = '0;
        {useLiteral, destFile, bitSel} = '0;
        {watchdogClearInstr, sleepInstr, watchdogTimeout} = 3'h0;
        mismatches = 0;
        num_checks = 0;
        prevSt = 8'h18;
        repeat (6) @(posedge sys_clk);
        chk8(statusOut, 8'h18);
        chk8(indirectPointer, 8'h00);
        rst <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            run_row(rows[i]);
            if (i == 10)
                chk8(indirectPointer, 8'h5A);
        end
        @(posedge sys_clk);
        instrValid <= 1'b0;
        @(negedge sys_clk);
        chk8(statusOut, prevSt);
        ev(3'b100, 8'hC8);
        ev(3'b010, 8'hD0);
        ev(3'b001, 8'hD8);
        ev(3'b100, 8'hC8);
        // Rotate into status: zero must not take the result bit
        run_row('{csbs_pkg::CSBS_OP_RRF, 7'h03, 8'h00, 8'h00, 2'h1,
                  8'h64, 9'h103, 8'h68});
        // Move that tries to set the reset-cause bits
        run_row('{csbs_pkg::CSBS_OP_MOVE, 7'h03, 8'h18, 8'h00, 2'h1,
                  8'h18, 9'h183, 8'h08});
        @(posedge sys_clk);
        instrValid <= 1'b0;
        @(negedge sys_clk);
        chk8(statusOut, 8'h08);
        @(posedge sys_clk);
        rst <= 1'b1;
        @(negedge sys_clk);
        chk8(statusOut, 8'h18);
        chk8(indirectPointer, 8'h00);
        @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk8(statusOut, 8'h18);
        ev(3'b101, 8'h08);
        ev(3'b011, 8'h10);
        // Literal add sets all flags; a clear of status keeps DC and C
        run_row('{csbs_pkg::CSBS_OP_ADD, 7'h03, 8'h01, 8'hFF, 2'h3,
                  8'h00, 9'h003, 8'h17});
        run_row('{csbs_pkg::CSBS_OP_CLR, 7'h03, 8'h00, 8'h00, 2'h1,
                  8'h00, 9'h003, 8'h17});
        @(posedge sys_clk);
        instrValid <= 1'b0;
        @(negedge sys_clk);
        chk8(statusOut, prevSt);
        end_of_test();
    end

    // Whole-run bound so a hang still reaches the verdict
    initial begin
        #(25 * 5000);
        mismatches++;
        end_of_test();
    end
endmodule : test_core_status_bank_select

//--- logic/csbs_alu_flags.sv
`timescale 1ns/10ps
module csbs_alu_flags (
    input  csbs_pkg::csbs_alu_req_type req,
    output logic [7:0]                 result,
    output csbs_pkg::csbs_flags_type   flags,
    output logic                       zeroUpd,
    output logic                       arithUpd
);
    logic [4:0] lowSum;
    logic [8:0] fullSum;
    logic [7:0] addend;
    logic       isSub;

    always_comb begin
        isSub    = (req.op == csbs_pkg::CSBS_OP_SUB);
        // Subtract as A + ~B + 1, so carries read as inverted borrows
        addend   = isSub ? ~req.opB : req.opB; // RL11
        lowSum   = {1'b0, req.opA[3:0]} + {1'b0, addend[3:0]}
                   + {4'h0, isSub};
        fullSum  = {1'b0, req.opA} + {1'b0, addend} + {8'h00, isSub};
        result   = 8'h00;
        flags    = '0;
        zeroUpd  = 1'b0;
        arithUpd = 1'b0;
        case (req.op)
            csbs_pkg::CSBS_OP_ADD, csbs_pkg::CSBS_OP_SUB: begin
                result       = fullSum[7:0];
                flags.nibble = lowSum[4]; // RL9
                flags.carry  = fullSum[8]; // RL10
                zeroUpd      = 1'b1;
                arithUpd     = 1'b1;
            end
            csbs_pkg::CSBS_OP_AND: begin
                result  = req.opA & req.opB;
                zeroUpd = 1'b1;
            end
            csbs_pkg::CSBS_OP_OR: begin
                result  = req.opA | req.opB;
                zeroUpd = 1'b1;
            end
            csbs_pkg::CSBS_OP_XOR: begin
                result  = req.opA ^ req.opB;
                zeroUpd = 1'b1;
            end
            csbs_pkg::CSBS_OP_RLF: begin
                result      = {req.opA[6:0], req.carryIn};
                flags.carry = req.opA[7]; // RL12
            end
            csbs_pkg::CSBS_OP_RRF: begin
                result      = {req.carryIn, req.opA[7:1]};
                flags.carry = req.opA[0]; // RL12
            end
            csbs_pkg::CSBS_OP_CLR: begin
                result  = 8'h00;
                zeroUpd = 1'b1;
            end
            csbs_pkg::CSBS_OP_MOVE: result = req.opA;
            csbs_pkg::CSBS_OP_BSF:
                result = req.opA | (8'h01 << req.bitSel);
            csbs_pkg::CSBS_OP_BCF:
                result = req.opA & ~(8'h01 << req.bitSel);
            csbs_pkg::CSBS_OP_SWAP: result = {req.opA[3:0], req.opA[7:4]};
            default: result = 8'h00;
        endcase
        flags.zero = (result == 8'h00); // RL8
    end

endmodule : csbs_alu_flags

//--- logic/csbs_pkg.sv
package csbs_pkg;

    // Register map (printed offsets, data-memory addresses)
    localparam logic [8:0] IND_WINDOW_ADDR  = 9'h180;
    localparam logic [8:0] STATUS_ADDR      = 9'h183;
    localparam logic [8:0] IND_POINTER_ADDR = 9'h184;
    // Low seven bits that name each register in every bank
    localparam logic [6:0] IND_WINDOW_OFS   = 7'h00;
    localparam logic [6:0] STATUS_OFS       = 7'h03;
    localparam logic [6:0] IND_POINTER_OFS  = 7'h04;

    // Status field positions
    localparam int BIT_IND_BANK   = 7;
    localparam int BIT_DIR_BANK_H = 6;
    localparam int BIT_DIR_BANK_L = 5;
    localparam int BIT_WDT_EXP_N  = 4;
    localparam int BIT_SLEEP_N    = 3;
    localparam int BIT_ZERO       = 2;
    localparam int BIT_NIBBLE     = 1;
    localparam int BIT_CARRY      = 0;

    // Power-on values
    localparam logic [2:0] BANK_RESET  = 3'h0;
    localparam logic       WDT_N_RESET = 1'b1;
    localparam logic       SLP_N_RESET = 1'b1;
    localparam logic [2:0] ARITH_RESET = 3'h0;
    localparam logic [7:0] PTR_RESET   = 8'h00;

    typedef enum logic [3:0] {
        CSBS_OP_NONE   = 4'b0000,
        CSBS_OP_ADD    = 4'b0001,
        CSBS_OP_SUB    = 4'b0010,
        CSBS_OP_AND    = 4'b0011,
        CSBS_OP_OR     = 4'b0100,
        CSBS_OP_XOR    = 4'b0101,
        CSBS_OP_RLF    = 4'b0110,
        CSBS_OP_RRF    = 4'b0111,
        CSBS_OP_CLR    = 4'b1000,
        CSBS_OP_MOVE   = 4'b1001,
        CSBS_OP_BSF    = 4'b1010,
        CSBS_OP_BCF    = 4'b1011,
        CSBS_OP_SWAP   = 4'b1100
    } csbs_op_type;

    typedef struct packed {
        logic        zero;
        logic        nibble;
        logic        carry;
    } csbs_flags_type;

    typedef struct packed {
        csbs_op_type op;
        logic [7:0]  opA;
        logic [7:0]  opB;
        logic        carryIn;
        logic [2:0]  bitSel;
    } csbs_alu_req_type;

endpackage : csbs_pkg

//--- logic/csbs_status_bank.sv
`timescale 1ns/10ps
// Contract
// RL1 - The indirect bank bit picks banks 2/3 when set, banks 0/1 when clear.
// RL2 - The direct bank field picks one of four 128-location banks.
// RL3 - An instruction that updates zero/nibble/carry overrides the write.
// RL4 - The watchdog-expired and sleep-entered flags ignore register writes.
// RL5 - Clearing the status register zeroes bank bits and sets zero only.
// RL6 - Watchdog-expired_n sets on power-up, clear or sleep; clears on timeout.
// RL7 - Sleep-entered_n sets on power-up or watchdog clear; clears on sleep.
// RL8 - Zero flag is set for a zero result and cleared otherwise.
// RL9 - Nibble flag is the carry out of result bit 3 on add and subtract.
// RL10 - Carry flag is the carry out of result bit 7 on add and subtract.
// RL11 - Subtraction adds the two's complement, so carries are inverted borrows.
// RL12 - Rotates load carry with the bit that is shifted out.
// RL13 - Software should alter status only with bit set/clear, swap or move.
// RL14 - Indirect address is the indirect bank bit above the pointer.
// RL15 - Direct address is the two bank bits above the 7-bit file address.
module csbs_status_bank (
    input  logic                       sys_clk,
    input  logic                       rst,
    input  logic                       instrValid,
    input  csbs_pkg::csbs_op_type      instrOp,
    input  logic [6:0]                 fileAddr,
    input  logic [7:0]                 workingReg,
    input  logic [7:0]                 literalVal,
    input  logic                       useLiteral,
    input  logic                       destFile,
    input  logic [2:0]                 bitSel,
    input  logic [7:0]                 memRdData,
    input  logic                       watchdogClearInstr,
    input  logic                       sleepInstr,
    input  logic                       watchdogTimeout,
    output logic [8:0]                 dataAddr,
    output logic [7:0]                 aluResult,
    output logic                       memWrEn,
    output logic [7:0]                 statusOut,
    output logic [7:0]                 indirectPointer
);
    logic [2:0]               bankBits_ff;
    logic                     wdtExpN_ff;
    logic                     sleepN_ff;
    csbs_pkg::csbs_flags_type arith_ff;
    logic [7:0]               pointer_ff;
    logic [7:0]               statusVal;
    logic                     isIndirect;
    logic                     hitStatus;
    logic                     hitPointer;
    logic [7:0]               fileData;
    csbs_pkg::csbs_alu_req_type aluReq;
    csbs_pkg::csbs_flags_type aluFlags;
    logic                     zeroUpd;
    logic                     arithUpd;
    logic                     wrFile;
    logic [8:0]               pointerAddr;
    logic                     isRotate;
    logic                     flagOp;
    logic                     flagWr;

    assign statusVal = {bankBits_ff, wdtExpN_ff, sleepN_ff,
                        arith_ff.zero, arith_ff.nibble, arith_ff.carry};
    assign statusOut = statusVal;
    assign indirectPointer = pointer_ff;

    // Indirect slot redirects through the pointer, banks paired by one bit
    assign isIndirect  = (fileAddr == csbs_pkg::IND_WINDOW_OFS);
    assign pointerAddr = {bankBits_ff[2], pointer_ff}; // RL1 RL14
    always_comb begin
        if (isIndirect) begin
            dataAddr = pointerAddr;
        end else begin
            dataAddr = {bankBits_ff[1:0], fileAddr}; // RL2 RL15
        end
    end

    // Core registers mirror into every bank at the same low offset
    assign hitStatus  = (dataAddr[6:0] == csbs_pkg::STATUS_OFS);
    assign hitPointer = (dataAddr[6:0] == csbs_pkg::IND_POINTER_OFS);
    always_comb begin
        if (hitStatus) begin
            fileData = statusVal;
        end else if (hitPointer) begin
            fileData = pointer_ff;
        end else begin
            fileData = memRdData;
        end
    end

    always_comb begin
        aluReq.op      = instrOp;
        aluReq.carryIn = arith_ff.carry;
        aluReq.bitSel  = bitSel;
        aluReq.opA     = useLiteral ? literalVal : fileData;
        aluReq.opB     = workingReg;
        if (instrOp == csbs_pkg::CSBS_OP_SUB) begin
            // Subtract forms operand minus working register
            aluReq.opA = useLiteral ? literalVal : fileData;
        end
        if (instrOp == csbs_pkg::CSBS_OP_MOVE) begin
            aluReq.opA = workingReg;
        end
    end

    csbs_alu_flags u_alu (
        .req      (aluReq),
        .result   (aluResult),
        .flags    (aluFlags),
        .zeroUpd  (zeroUpd),
        .arithUpd (arithUpd)
    );

    assign wrFile  = instrValid && destFile && !useLiteral;
    assign memWrEn = wrFile && !hitStatus && !hitPointer;

    // Any flag-changing op locks all three flags against the write
    assign isRotate = (instrOp == csbs_pkg::CSBS_OP_RLF) ||
                      (instrOp == csbs_pkg::CSBS_OP_RRF);
    assign flagOp   = zeroUpd || arithUpd || isRotate;
    assign flagWr   = wrFile && hitStatus && !flagOp; // RL3

    // Bank bits: plain writable through the status register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bankBits_ff <= csbs_pkg::BANK_RESET;
        end else if (wrFile && hitStatus) begin
            bankBits_ff <= aluResult[7:5]; // RL5
        end
    end

    // Reset-cause flags move only on hardware events
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wdtExpN_ff <= csbs_pkg::WDT_N_RESET;
            sleepN_ff  <= csbs_pkg::SLP_N_RESET;
        end else begin // RL4
            // Time-out wins: it marks why the part woke or reset
            if (watchdogTimeout) begin
                wdtExpN_ff <= 1'b0; // RL6
            end else if (watchdogClearInstr || sleepInstr) begin
                wdtExpN_ff <= 1'b1; // RL6
            end
            if (sleepInstr) begin
                sleepN_ff <= 1'b0; // RL7
            end else if (watchdogClearInstr) begin
                sleepN_ff <= 1'b1; // RL7
            end
        end
    end

    // Flag results beat a register write to the same bits
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            arith_ff <= csbs_pkg::ARITH_RESET;
        end else if (instrValid) begin
            if (zeroUpd) begin
                arith_ff.zero <= aluFlags.zero; // RL3 RL8
            end else if (flagWr) begin
                arith_ff.zero <= aluResult[csbs_pkg::BIT_ZERO];
            end
            if (arithUpd) begin
                arith_ff.nibble <= aluFlags.nibble; // RL3 RL9
            end else if (flagWr) begin
                arith_ff.nibble <= aluResult[csbs_pkg::BIT_NIBBLE];
            end
            if (arithUpd || isRotate) begin
                arith_ff.carry <= aluFlags.carry; // RL3 RL10 RL12
            end else if (flagWr) begin
                arith_ff.carry <= aluResult[csbs_pkg::BIT_CARRY];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pointer_ff <= csbs_pkg::PTR_RESET;
        end else if (wrFile && hitPointer) begin
            pointer_ff <= aluResult;
        end
    end

    AST_RESET_FLAGS_HW_ONLY: assert property (
        @(posedge sys_clk) disable iff (rst) // RL4
        (!watchdogTimeout && !watchdogClearInstr && !sleepInstr)
        |=> ($stable(wdtExpN_ff) && $stable(sleepN_ff)))
        else $error("reset-cause flag changed without an event");

    AST_TIMEOUT_CLEARS: assert property (
        @(posedge sys_clk) disable iff (rst) // RL6
        watchdogTimeout |=> !statusOut[csbs_pkg::BIT_WDT_EXP_N])
        else $error("watchdog flag not cleared by time-out");

    AST_SLEEP_SETS: assert property (
        @(posedge sys_clk) disable iff (rst) // RL7
        (sleepInstr && !watchdogTimeout) |=>
        (!statusOut[csbs_pkg::BIT_SLEEP_N] &&
         statusOut[csbs_pkg::BIT_WDT_EXP_N]))
        else $error("sleep did not update reset-cause flags");

    AST_CLEAR_STATUS: assert property (
        @(posedge sys_clk) disable iff (rst) // RL5
        (instrValid && instrOp == csbs_pkg::CSBS_OP_CLR && wrFile &&
         hitStatus) |=> (statusOut[7:5] == 3'h0 &&
         statusOut[csbs_pkg::BIT_ZERO] &&
         statusOut[1:0] == $past(statusOut[1:0])))
        else $error("clear of status gave wrong value");

    AST_DIRECT_ADDR: assert property (
        @(posedge sys_clk) disable iff (rst) // RL2
        !isIndirect |-> dataAddr == {statusOut[6:5], fileAddr})
        else $error("direct address bank mismatch");

    AST_INDIRECT_ADDR: assert property (
        @(posedge sys_clk) disable iff (rst) // RL1
        isIndirect |-> dataAddr == {statusOut[7], indirectPointer})
        else $error("indirect address bank mismatch");

    AST_ADD_CARRY: assert property (
        @(posedge sys_clk) disable iff (rst) // RL10
        (instrValid && instrOp == csbs_pkg::CSBS_OP_ADD) |=>
        statusOut[0] == ({1'b0, $past(aluReq.opA)} +
                         {1'b0, $past(aluReq.opB)} > 9'h0FF))
        else $error("add carry wrong");

    AST_SUB_BORROW: assert property (
        @(posedge sys_clk) disable iff (rst) // RL11
        (instrValid && instrOp == csbs_pkg::CSBS_OP_SUB) |=>
        statusOut[0] == ($past(aluReq.opA) >= $past(aluReq.opB)))
        else $error("subtract borrow polarity wrong");

    AST_ZERO_FLAG: assert property (
        @(posedge sys_clk) disable iff (rst) // RL8
        (instrValid && zeroUpd) |=>
        statusOut[2] == ($past(aluResult) == 8'h00))
        else $error("zero flag wrong");

    AST_ROTATE_CARRY: assert property (
        @(posedge sys_clk) disable iff (rst) // RL12
        (instrValid && instrOp == csbs_pkg::CSBS_OP_RLF) |=>
        statusOut[0] == $past(aluReq.opA[7]))
        else $error("rotate carry wrong");

    AST_FLAGS_LOCKED: assert property (
        @(posedge sys_clk) disable iff (rst) // RL3
        (instrValid && wrFile && hitStatus && flagOp && !arithUpd) |=>
        (statusOut[csbs_pkg::BIT_NIBBLE] ==
         $past(statusOut[csbs_pkg::BIT_NIBBLE])))
        else $error("status write reached a locked flag");

    AST_ROTATE_ZERO_KEPT: assert property (
        @(posedge sys_clk) disable iff (rst) // RL3
        (instrValid && isRotate) |=>
        (statusOut[csbs_pkg::BIT_ZERO] ==
         $past(statusOut[csbs_pkg::BIT_ZERO])))
        else $error("rotate changed the zero flag");

endmodule : csbs_status_bank
